// ### branch_bitop_regs.vh
// Constants for the branch and bit-operation execute slice.
// Assumes a 25 MHz core clock and an AXI4-Lite register bus.
// Notes on behaviour
// - Upper byte 1110_0101 decodes the jump when overflow is clear; low byte is the offset.
// - That jump is taken only when overflow reads 0, otherwise fall through.
// - Upper byte 1110_0001 decodes the jump when zero is clear; low byte is the offset.
// - That jump is taken only when zero reads 0, otherwise fall through.
// - A taken jump loads instruction address plus 2 plus twice the offset; flags untouched.
// - Conditional jumps are one word, one cycle untaken, two cycles taken.
// - Taken: decode, read, process, write counter in Q4, then one idle cycle.
// - Top nibble 1101 with bit 11 zero decodes the unconditional jump, 11-bit offset.
// - The unconditional jump always takes two cycles, the second idle.
// - Nibble 1000 sets the indexed bit of the addressed file register.
// - Bank bit 0 uses the access bank, 1 uses the bank select register.
// - Bank bit 0 with extended set and address at most 5Fh uses indexed offset mode.
// - Upper byte 1110_0111 decodes the jump when negative is clear.
// - That jump is taken only when negative reads 0.
`ifndef BRANCH_BITOP_REGS_VH
`define BRANCH_BITOP_REGS_VH
`define ADDR_CTRL       4'h0
`define ADDR_INSTR      4'h4
`define ADDR_STATUS     4'h8
`define ADDR_PC         4'hC
`define OP_NOVF         8'hE5
`define OP_NZERO        8'hE1
`define OP_NNEG         8'hE7
`define OP_REL          5'h1A
`define OP_SETBIT       4'h8
`define OP_SKIPCLR      4'hB
`define OP_SKIPSET      4'hA
`define IDX_LIMIT       8'h5F
`define ACCESS_SPLIT    8'h60
`define BANK_RST        4'h0
`define CTRL_EXT_BIT    0
`define CTRL_GO_BIT     1
`endif

// ### branch_and_bit_op_execute.v
// Execute slice for flag-conditional jumps, the relative jump, bit set and bit-test skips.
// Assumes an AXI4-Lite master that holds valid and payload until taken.
`timescale 1ns/1ns
`default_nettype none
`include "branch_bitop_regs.vh"
module branch_and_bit_op_execute (
    // Clock and reset
    input  wire        clk,
    input  wire        arst_n,
    // AXI4-Lite write address and data
    input  wire [3:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output wire        s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output wire        s_axi_wready,
    // AXI4-Lite write response
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    // AXI4-Lite read
    input  wire [3:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output wire        s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    // Core side
    input  wire        flag_neg,
    input  wire        flag_ovf,
    input  wire        flag_zero,
    input  wire [3:0]  bank_select_reg,
    output reg  [11:0] file_addr,
    output reg         file_rd,
    input  wire [7:0]  file_rdata,
    output reg         file_wr,
    output reg  [7:0]  file_wdata,
    output reg         indexed_mode,
    output reg         busy
);
    localparam [3:0] Q1 = 4'b0001;
    localparam [3:0] Q2 = 4'b0010;
    localparam [3:0] Q3 = 4'b0100;
    localparam [3:0] Q4 = 4'b1000;

    reg  [20:0] pc;
    reg  [15:0] instr;
    reg         ext_en;
    reg  [3:0]  qph;
    reg         run;
    reg         idle_next;
    reg         in_idle;
    reg  [7:0]  data;
    reg         take;
    reg  [1:0]  last_cycles;
    reg         aw_held;
    reg         w_held;
    reg  [3:0]  aw_addr;
    reg  [31:0] w_data;

    // Decode, Q1
    wire is_novf  = instr[15:8] == `OP_NOVF;
    wire is_nzero = instr[15:8] == `OP_NZERO;
    wire is_nneg  = instr[15:8] == `OP_NNEG;
    wire is_rel   = instr[15:11] == `OP_REL;
    wire is_set   = instr[15:12] == `OP_SETBIT;
    wire is_sclr  = instr[15:12] == `OP_SKIPCLR;
    wire is_sset  = instr[15:12] == `OP_SKIPSET;
    wire is_cond  = is_novf | is_nzero | is_nneg;
    wire cond_ok  = (is_novf & ~flag_ovf)
                  | (is_nzero & ~flag_zero)
                  | (is_nneg & ~flag_neg);
    wire [20:0] off8  = {{12{instr[7]}}, instr[7:0], 1'b0};
    wire [20:0] off11 = {{9{instr[10]}}, instr[10:0], 1'b0};
    // Counter has already advanced by 2 when the target is formed
    wire [20:0] target = pc + (is_rel ? off11 : off8);
    wire [2:0]  bidx   = instr[11:9];
    wire        bank_a = instr[8];
    wire [7:0]  fa     = instr[7:0];
    wire        bit_v  = data[bidx];

    // Write channel: address and data accepted in either order
    assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
    assign s_axi_wready  = ~w_held & ~s_axi_bvalid;
    assign s_axi_arready = ~s_axi_rvalid;
    wire aw_now = aw_held | (s_axi_awvalid & s_axi_awready);
    wire w_now  = w_held | (s_axi_wvalid & s_axi_wready);
    wire [3:0]  wa = aw_held ? aw_addr : s_axi_awaddr;
    wire [31:0] wd = w_held ? w_data : s_axi_wdata;
    wire do_wr  = aw_now & w_now & ~s_axi_bvalid;
    wire go     = do_wr & (wa == `ADDR_CTRL) & s_axi_wstrb[0] & wd[`CTRL_GO_BIT] & ~run;

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 4'h0;
            w_data <= 32'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'h0;
            s_axi_rvalid <= 1'b0;
            s_axi_rresp <= 2'h0;
            s_axi_rdata <= 32'h0;
            ext_en <= 1'b0;
            instr <= 16'h0;
            pc <= 21'h0;
        end else begin
            if (s_axi_awvalid & s_axi_awready & ~do_wr) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid & s_axi_wready & ~do_wr) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
            end
            if (do_wr) begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (wa == `ADDR_STATUS) ? 2'h2 : 2'h0;
                // Loads are ignored while an instruction runs to keep decode stable
                if (!run && wa == `ADDR_CTRL && s_axi_wstrb[0])
                    ext_en <= wd[`CTRL_EXT_BIT];
                if (!run && wa == `ADDR_INSTR) begin
                    if (s_axi_wstrb[0]) instr[7:0] <= wd[7:0];
                    if (s_axi_wstrb[1]) instr[15:8] <= wd[15:8];
                end
                if (!run && wa == `ADDR_PC) begin
                    if (s_axi_wstrb[0]) pc[7:0] <= wd[7:0];
                    if (s_axi_wstrb[1]) pc[15:8] <= wd[15:8];
                    if (s_axi_wstrb[2]) pc[20:16] <= wd[20:16];
                end
            end else if (s_axi_bvalid & s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
            if (s_axi_arvalid & s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= 2'h0;
                case (s_axi_araddr)
                    `ADDR_CTRL:   s_axi_rdata <= {30'h0, 1'b0, ext_en};
                    `ADDR_INSTR:  s_axi_rdata <= {16'h0, instr};
                    `ADDR_STATUS: s_axi_rdata <= {19'h0, last_cycles, take, indexed_mode,
                                                  busy, data};
                    `ADDR_PC:     s_axi_rdata <= {11'h0, pc};
                    default: begin
                        s_axi_rdata <= 32'h0;
                        s_axi_rresp <= 2'h2;
                    end
                endcase
            end else if (s_axi_rvalid & s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
            // Counter advance past the fetched word, then branch write in Q4
            if (go)
                pc <= pc + 21'h2;
            else if (run && !in_idle && qph == Q4 && take && !(is_sclr | is_sset))
                pc <= target;
            else if (run && !in_idle && qph == Q4 && take)
                pc <= pc + 21'h2;
        end
    end

    // Quarter-phase sequencer
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            qph <= Q1;
            run <= 1'b0;
            idle_next <= 1'b0;
            in_idle <= 1'b0;
            data <= 8'h0;
            take <= 1'b0;
            last_cycles <= 2'h0;
            file_addr <= 12'h0;
            file_rd <= 1'b0;
            file_wr <= 1'b0;
            file_wdata <= 8'h0;
            indexed_mode <= 1'b0;
            busy <= 1'b0;
        end else begin
            file_rd <= 1'b0;
            file_wr <= 1'b0;
            if (go) begin
                run <= 1'b1;
                busy <= 1'b1;
                qph <= Q1;
                in_idle <= 1'b0;
                take <= 1'b0;
            end else if (run) begin
                case (qph)
                    Q1: begin
                        qph <= Q2;
                        if (!in_idle) begin
                            take <= is_rel | (is_cond & cond_ok);
                            if (is_set | is_sclr | is_sset) begin
                                file_rd <= 1'b1;
                                indexed_mode <= ~bank_a & ext_en & (fa <= `IDX_LIMIT);
                                // Access bank splits low RAM from the upper special area
                                if (bank_a)
                                    file_addr <= {bank_select_reg, fa};
                                else if (fa < `ACCESS_SPLIT)
                                    file_addr <= {`BANK_RST, fa};
                                else
                                    file_addr <= {4'hF, fa};
                            end else begin
                                indexed_mode <= 1'b0;
                            end
                        end
                    end
                    Q2: begin
                        qph <= Q3;
                        if (!in_idle && (is_set | is_sclr | is_sset))
                            data <= file_rdata;
                    end
                    Q3: begin
                        qph <= Q4;
                        if (!in_idle && is_set)
                            file_wdata <= data | (8'h01 << bidx);
                        if (!in_idle && ((is_sclr & ~bit_v) | (is_sset & bit_v)))
                            take <= 1'b1;
                    end
                    Q4: begin
                        qph <= Q1;
                        if (in_idle) begin
                            run <= 1'b0;
                            busy <= 1'b0;
                            in_idle <= 1'b0;
                            last_cycles <= 2'h2;
                        end else begin
                            if (is_set)
                                file_wr <= 1'b1;
                            // Untaken jump does nothing here and ends after one cycle
                            if (take) begin
                                in_idle <= 1'b1;
                            end else begin
                                run <= 1'b0;
                                busy <= 1'b0;
                                last_cycles <= 2'h1;
                            end
                        end
                    end
                    default: qph <= Q1;
                endcase
            end
        end
    end
endmodule // branch_and_bit_op_execute
`default_nettype wire

// ### branch_exec_monitor.sv
// Assertion checker for the branch and bit-operation execute slice.
// Assumes it is bound to the top module and sees only that module's ports.
`timescale 1ns/1ns
`default_nettype none
`include "branch_bitop_regs.vh"
module branch_exec_monitor (
    // Clock, reset and core side
    input wire logic        clk, arst_n, busy, file_rd, file_wr,
    // Register bus
    input wire logic [3:0]  s_axi_awaddr,
    input wire logic [31:0] s_axi_wdata,
    input wire logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready,
    input wire logic        s_axi_bvalid, s_axi_arvalid, s_axi_arready, s_axi_rvalid
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    sequence quad_busy; busy [*4]; endsequence
    sequence wr_both; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready; endsequence
    // A taken jump or a satisfied skip adds exactly one idle instruction cycle
    a_busy_len: assert property ($rose(busy) |-> quad_busy ##1 (!busy or quad_busy ##1 !busy))
        else $error("busy length is neither one nor two instruction cycles");
    a_go_starts: assert property (wr_both ##0 (s_axi_awaddr == `ADDR_CTRL && s_axi_wdata[`CTRL_GO_BIT] && !busy) |=> $rose(busy))
        else $error("start write did not raise busy");
    a_rd_single: assert property (file_rd |=> !file_rd)
        else $error("file read longer than one cycle");
    a_wr_single: assert property (file_wr |=> !file_wr)
        else $error("file write longer than one cycle");
    a_rd_in_busy: assert property (file_rd |-> busy)
        else $error("file read outside an instruction");
    a_wr_resp: assert property (wr_both |=> s_axi_bvalid)
        else $error("write response late");
    a_rd_resp: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data late");
    a_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read address accepted while data pending");
endmodule // branch_exec_monitor
bind branch_and_bit_op_execute branch_exec_monitor u_mon (.clk, .arst_n, .busy, .file_rd,
    .file_wr, .s_axi_awaddr, .s_axi_wdata, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid);
`default_nettype wire

// ### branch_and_bit_op_execute_tb.sv
// Self-checking bench for the branch and bit-operation execute slice.
// Assumes the register map and opcode constants of the design header.
`timescale 1ns/1ns
`default_nettype none
`include "branch_bitop_regs.vh"
module branch_and_bit_op_execute_tb;
    logic        clk = 1'h0, arst_n = 1'h0, flag_neg = 1'h0, flag_ovf = 1'h0, flag_zero = 1'h0;
    logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic [3:0]  s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hF, bank_select_reg = 4'h0;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [7:0]  file_rdata = 8'h0, wd;
    wire         s_axi_awready, s_axi_wready, s_axi_arready, s_axi_bvalid, s_axi_rvalid;
    wire         file_rd, file_wr, indexed_mode, busy;
    wire [1:0]   s_axi_bresp, s_axi_rresp;
    wire [31:0]  s_axi_rdata;
    wire [11:0]  file_addr;
    wire [7:0]   file_wdata;
    logic [11:0] ra;
    logic        im;
    int          errors = 0, tests_run = 0, bcnt = 0, wcnt = 0;
    branch_and_bit_op_execute u_dut (.clk, .arst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .flag_neg, .flag_ovf, .flag_zero, .bank_select_reg,
        .file_addr, .file_rd, .file_rdata, .file_wr, .file_wdata, .indexed_mode, .busy);
    always #20 clk = ~clk;
    always @(posedge clk) begin
        bcnt <= bcnt + busy;
        if (file_rd) begin ra <= file_addr; im <= indexed_mode; end
        if (file_wr) begin wcnt <= wcnt + 1; wd <= file_wdata; end
    end
    task test_done;
        $display("comparisons %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task chk(input logic [31:0] got, exp, input string m);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED t=%0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask
    task hang;
        errors++;
        $display("CHECK FAILED t=%0t wait bound used up", $time);
        test_done;
    endtask
    // Address and data are offered together; each is dropped as soon as it is taken
    task axi_wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
        int n;
        @(posedge clk);
        n = 0;
        s_axi_awaddr <= a; s_axi_wdata <= d; s_axi_bready <= 1'h1;
        s_axi_awvalid <= 1'h1; s_axi_wvalid <= 1'h1;
        do begin
            @(posedge clk); n++;
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
        end while (!(s_axi_bvalid === 1'h1) && n < 50);
        s_axi_bready <= 1'h0; r = s_axi_bresp;
        if (n >= 50) hang;
    endtask
    task axi_rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        @(posedge clk);
        n = 0;
        s_axi_araddr <= a; s_axi_arvalid <= 1'h1; s_axi_rready <= 1'h1;
        do begin
            @(posedge clk); n++;
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'h0;
        end while (!(s_axi_rvalid === 1'h1) && n < 50);
        s_axi_rready <= 1'h0; d = s_axi_rdata; r = s_axi_rresp;
        if (n >= 50) hang;
    endtask
    // Flags packed as {negative, zero, overflow}
    function logic take(input logic [15:0] i, input logic [2:0] f, input logic [7:0] rd);
        if (i[15:8] == `OP_NOVF) return !f[0];
        if (i[15:8] == `OP_NZERO) return !f[1];
        if (i[15:8] == `OP_NNEG) return !f[2];
        if (i[15:11] == `OP_REL) return 1'h1;
        if (i[15:12] == `OP_SKIPCLR) return !rd[i[11:9]];
        if (i[15:12] == `OP_SKIPSET) return rd[i[11:9]];
        return 1'h0;
    endfunction
    function logic [20:0] next_pc(input logic [15:0] i, input logic [20:0] pc, input logic t);
        if (!t) return pc + 21'h2;
        if (i[15:13] == 3'h5) return pc + 21'h4;
        if (i[15:11] == `OP_REL) return pc + 21'h2 + {{9{i[10]}}, i[10:0], 1'h0};
        return pc + 21'h2 + {{12{i[7]}}, i[7:0], 1'h0};
    endfunction
    task run(input logic [15:0] i, input logic [20:0] pc, input logic [2:0] f, input logic ext,
             input logic [3:0] bs, input logic [7:0] rd);
        int b0, w0, n;
        logic [1:0] r;
        logic [31:0] d;
        logic t;
        {flag_neg, flag_zero, flag_ovf} <= f; bank_select_reg <= bs; file_rdata <= rd;
        axi_wr(`ADDR_INSTR, {16'h0, i}, r);
        axi_wr(`ADDR_PC, {11'h0, pc}, r);
        b0 = bcnt; w0 = wcnt; t = take(i, f, rd);
        axi_wr(`ADDR_CTRL, {30'h0, 1'h1, ext}, r);
        n = 0;
        while (busy !== 1'h0 && n < 40) begin @(posedge clk); n++; end
        if (n >= 40) hang;
        repeat (2) @(posedge clk);
        axi_rd(`ADDR_PC, d, r);
        chk(d[20:0], next_pc(i, pc, t), "pc");
        chk(bcnt - b0, t ? 8 : 4, "cycles");
        axi_rd(`ADDR_STATUS, d, r);
        chk(d[10], t, "take");
        chk(wcnt - w0, i[15:12] == `OP_SETBIT, "writes");
        if (i[15:12] == `OP_SETBIT) chk(wd, rd | (8'h1 << i[11:9]), "bit set");
        if (i[15:14] == 2'h2) begin
            chk(ra, i[8] ? {bs, i[7:0]} : {i[7:0] < `ACCESS_SPLIT ? 4'h0 : 4'hF, i[7:0]}, "bank");
            chk(im, !i[8] && ext && i[7:0] <= `IDX_LIMIT, "indexed");
        end
    endtask
    logic [15:0] base [7] = '{16'hE500, 16'hE100, 16'hE700, 16'hD000, 16'h8000, 16'hB000, 16'hA000};
    logic [15:0] mask [7] = '{16'h00FF, 16'h00FF, 16'h00FF, 16'h07FF, 16'h0FFF, 16'h0FFF, 16'h0FFF};
    logic [31:0] d;
    logic [1:0]  r;
    initial begin
        d = $urandom(32'h598513EE);
        repeat (6) @(posedge clk);
        arst_n <= 1'h1;
        axi_wr(`ADDR_STATUS, 32'h0, r);
        chk(r, 2'h2, "status write resp");
        axi_rd(4'h2, d, r);
        chk(d, 32'h0, "unmapped read data");
        chk(r, 2'h2, "unmapped read resp");
        run(16'hE580, 21'h0, 3'h0, 1'h0, 4'h3, 8'h0);
        run(16'hE57F, 21'h1FFFFE, 3'h1, 1'h0, 4'h3, 8'h0);
        run(16'hD400, 21'h800, 3'h7, 1'h0, 4'h0, 8'h0);
        run(16'hD3FF, 21'h100, 3'h0, 1'h0, 4'h0, 8'h0);
        run(16'h8E5F, 21'h40, 3'h0, 1'h1, 4'h5, 8'h0A);
        run(16'h8E60, 21'h40, 3'h0, 1'h1, 4'h5, 8'h0A);
        for (int k = 0; k < 42; k++) begin
            d = $urandom;
            run(base[k % 7] | (d[15:0] & mask[k % 7]), d[31:11], d[2:0], d[3], d[7:4], d[23:16]);
        end
        test_done;
    end
endmodule // branch_and_bit_op_execute_tb
`default_nettype wire
